/* File: pkg/embp_pkg.sv */
package embp_pkg;
  // Reset vector location in program space.
  localparam logic [15:0] EMBP_VECTOR_LO_ADDR = 16'h0000;
  localparam logic [15:0] EMBP_VECTOR_HI_ADDR = 16'h0001;
  // Bus phase timing counts, in clock cycles.
  localparam int EMBP_ADDR_CYCLES = 1;
  localparam int EMBP_DATA_CYCLES = 2;
  // Reset values of the driven pins.
  localparam logic EMBP_STROBE_IDLE = 1'b1;
  localparam logic EMBP_DIR_IDLE = 1'b1;
  typedef enum logic [2:0] {
    embp_idle,
    embp_addr,
    embp_latch,
    embp_data,
    embp_end,
    embp_float
  } embp_state_type;
endpackage

/* File: hdl/embp_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - One active-low address latch pulse opens every memory cycle.
// - High address, direction and space select are stable at the latch strobe rising edge.
// - Software float request tri-states both strobes, direction and both ports together.
// - Write data goes onto the multiplexed port on the same edge as the data strobe falls.
// - On-chip accesses keep the data strobe high for the whole cycle.
// - Direction line low only for external writes, high otherwise.
// - After reset, fetch vector from program 00h and 01h, start there.
// - Low address multiplexed with data on one port, high address on another.
module embp_port (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  // Core request side.
  input wire logic req_valid,
  input wire logic [15:0] req_addr,
  input wire logic req_write,
  input wire logic req_program,
  input wire logic req_internal,
  input wire logic [7:0] req_wdata,
  input wire logic float_request,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic vector_valid,
  output logic [15:0] start_address,
  // Pins.
  output logic addr_latch_strobe_n,
  output logic addr_latch_strobe_oe_n,
  output logic data_strobe_n,
  output logic data_strobe_oe_n,
  output logic read_write,
  output logic read_write_oe_n,
  output logic program_data_sel,
  input wire logic [7:0] mux_addr_data_in,
  output logic [7:0] mux_addr_data_out,
  output logic mux_addr_data_oe_n,
  output logic [7:0] high_addr,
  output logic high_addr_oe_n,
  input wire logic external_wait,
  input wire logic external_bus_request,
  output logic external_bus_grant
);
  embp_pkg::embp_state_type state;
  embp_pkg::embp_state_type next_state;
  logic [1:0] count;
  logic [7:0] ad_sync1, ad_sync2;
  logic wait_sync1, wait_sync2, breq_sync1, breq_sync2;
  logic cyc_write, cyc_internal, boot_done, boot_hi;
  logic [15:0] cyc_addr;
  logic [7:0] cyc_wdata;
  // Core requests are frozen until the reset vector has been fetched.
  wire logic boot_active = !boot_done;
  wire logic want_float = float_request || breq_sync2;
  wire logic start_cycle = boot_active || req_valid;
  wire logic [15:0] start_addr = boot_active ? (boot_hi ? embp_pkg::EMBP_VECTOR_HI_ADDR :
    embp_pkg::EMBP_VECTOR_LO_ADDR) : req_addr;
  wire logic count_last = (count == 2'(embp_pkg::EMBP_DATA_CYCLES - 1));
  wire logic data_done = count_last && !(wait_sync2 && !cyc_internal);
  wire logic floated = (state == embp_pkg::embp_float);

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ad_sync1 <= 8'h00;
      ad_sync2 <= 8'h00;
      wait_sync1 <= 1'b0;
      wait_sync2 <= 1'b0;
      breq_sync1 <= 1'b0;
      breq_sync2 <= 1'b0;
    end else if (clock_en) begin
      ad_sync1 <= mux_addr_data_in;
      ad_sync2 <= ad_sync1;
      wait_sync1 <= external_wait;
      wait_sync2 <= wait_sync1;
      breq_sync1 <= external_bus_request;
      breq_sync2 <= breq_sync1;
    end
  end

  // ==========================================================
  // Cycle sequencer
  always_comb begin
    next_state = state;
    case (state)
      embp_pkg::embp_idle: begin
        if (want_float) begin
          next_state = embp_pkg::embp_float;
        end else if (start_cycle) begin
          next_state = embp_pkg::embp_addr;
        end
      end
      embp_pkg::embp_addr: next_state = embp_pkg::embp_latch;
      embp_pkg::embp_latch: next_state = embp_pkg::embp_data;
      embp_pkg::embp_data: begin
        if (data_done) begin
          next_state = embp_pkg::embp_end;
        end
      end
      embp_pkg::embp_end: next_state = embp_pkg::embp_idle;
      embp_pkg::embp_float: begin
        if (!want_float) begin
          next_state = embp_pkg::embp_idle;
        end
      end
      default: next_state = embp_pkg::embp_idle;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= embp_pkg::embp_idle;
      count <= 2'b00;
      cyc_write <= 1'b0;
      cyc_internal <= 1'b0;
      cyc_addr <= 16'h0000;
      cyc_wdata <= 8'h00;
      program_data_sel <= 1'b1;
      boot_done <= 1'b0;
      boot_hi <= 1'b0;
      start_address <= 16'h0000;
      vector_valid <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      req_ready <= 1'b0;
    end else if (clock_en) begin
      state <= next_state;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      if (state == embp_pkg::embp_idle && next_state == embp_pkg::embp_addr) begin
        cyc_addr <= start_addr;
        cyc_write <= !boot_active && req_write;
        cyc_internal <= !boot_active && req_internal;
        cyc_wdata <= req_wdata;
        program_data_sel <= boot_active || req_program;
        req_ready <= !boot_active;
      end
      // The counter stops at its last value while the wait input stretches the cycle, so it cannot wrap.
      if (state != embp_pkg::embp_data || data_done) begin
        count <= 2'b00;
      end else if (!count_last) begin
        count <= 2'(count + 2'd1);
      end
      if (state == embp_pkg::embp_end) begin
        // The pin synchroniser is two deep, so the byte taken here stood on the bus one cycle before the strobe rose.
        // Memory must therefore drive read data from the cycle in which the strobe falls.
        if (boot_active) begin
          if (boot_hi) begin
            start_address[7:0] <= ad_sync2;
            boot_done <= 1'b1;
            vector_valid <= 1'b1;
          end else begin
            start_address[15:8] <= ad_sync2;
            boot_hi <= 1'b1;
          end
        end else begin
          rsp_valid <= 1'b1;
          rsp_rdata <= ad_sync2;
        end
      end
    end
  end

  // ==========================================================
  // Pin drivers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_latch_strobe_n <= embp_pkg::EMBP_STROBE_IDLE;
      data_strobe_n <= embp_pkg::EMBP_STROBE_IDLE;
      read_write <= embp_pkg::EMBP_DIR_IDLE;
      mux_addr_data_out <= 8'h00;
      mux_addr_data_oe_n <= 1'b1;
      high_addr <= 8'h00;
      addr_latch_strobe_oe_n <= 1'b0;
      data_strobe_oe_n <= 1'b0;
      read_write_oe_n <= 1'b0;
      high_addr_oe_n <= 1'b0;
      external_bus_grant <= 1'b0;
    end else if (clock_en) begin
      // All bus pins except the space select float as one group.
      addr_latch_strobe_oe_n <= next_state == embp_pkg::embp_float;
      data_strobe_oe_n <= next_state == embp_pkg::embp_float;
      read_write_oe_n <= next_state == embp_pkg::embp_float;
      high_addr_oe_n <= next_state == embp_pkg::embp_float;
      external_bus_grant <= floated && breq_sync2;
      addr_latch_strobe_n <= !(state == embp_pkg::embp_addr);
      if (state == embp_pkg::embp_addr) begin
        // Address and direction set up with the strobe low; high address and direction held past its rise.
        mux_addr_data_out <= cyc_addr[7:0];
        high_addr <= cyc_addr[15:8];
        mux_addr_data_oe_n <= 1'b0;
        read_write <= !(cyc_write && !cyc_internal);
      end else if (state == embp_pkg::embp_latch) begin
        mux_addr_data_out <= cyc_wdata;
        mux_addr_data_oe_n <= !cyc_write || cyc_internal;
        data_strobe_n <= cyc_internal;
      end else if (state == embp_pkg::embp_data && data_done) begin
        data_strobe_n <= 1'b1;
      end else if (state == embp_pkg::embp_end || floated) begin
        read_write <= embp_pkg::EMBP_DIR_IDLE;
        mux_addr_data_oe_n <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  a_strobe_single_pulse: assert property (@(posedge clock) disable iff (rst)
    clock_en && !addr_latch_strobe_n |=> addr_latch_strobe_n || !clock_en)
    else $error("address latch strobe held low for more than one cycle");
  a_addr_stable_rise: assert property (@(posedge clock) disable iff (rst)
    clock_en && !addr_latch_strobe_n ##1 clock_en |-> $stable(high_addr) && $stable(read_write) &&
      $stable(program_data_sel))
    else $error("address or direction changed at latch strobe rise");
  a_float_group: assert property (@(posedge clock) disable iff (rst)
    addr_latch_strobe_oe_n == data_strobe_oe_n && data_strobe_oe_n == read_write_oe_n &&
      read_write_oe_n == high_addr_oe_n && (!addr_latch_strobe_oe_n || mux_addr_data_oe_n))
    else $error("bus pins not floated together");
  a_write_data_ready: assert property (@(posedge clock) disable iff (rst)
    $fell(data_strobe_n) && !read_write |-> !mux_addr_data_oe_n && mux_addr_data_out == cyc_wdata)
    else $error("write data not valid at data strobe fall");
  a_internal_no_ds: assert property (@(posedge clock) disable iff (rst)
    cyc_internal && state != embp_pkg::embp_idle && state != embp_pkg::embp_addr |-> data_strobe_n)
    else $error("data strobe active on internal access");
  a_dir_write_only: assert property (@(posedge clock) disable iff (rst)
    !read_write |-> cyc_write && !cyc_internal)
    else $error("direction low outside external write");
  a_boot_vector: assert property (@(posedge clock) disable iff (rst)
    !addr_latch_strobe_n && !boot_done |-> program_data_sel &&
      {high_addr, mux_addr_data_out} ==
      (boot_hi ? embp_pkg::EMBP_VECTOR_HI_ADDR : embp_pkg::EMBP_VECTOR_LO_ADDR))
    else $error("reset vector fetched from wrong address");
  a_grant_floated: assert property (@(posedge clock) disable iff (rst)
    external_bus_grant |-> addr_latch_strobe_oe_n && high_addr_oe_n)
    else $error("bus granted while still driving");
endmodule
`default_nettype wire

/* File: tb/embp_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// External program and data memory behind the multiplexed bus.
module embp_mem_model (
  // Bus pins.
  input wire logic clock,
  input wire logic addr_latch_strobe_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic program_data_sel,
  input wire logic [7:0] high_addr,
  input wire logic [7:0] bus,
  // Model view.
  output logic [7:0] drive,
  output logic [15:0] lat_addr,
  output logic lat_write,
  output logic lat_prog,
  output logic [7:0] wr_data
);
  logic [7:0] mem [int];
  logic [7:0] last = 8'h00;
  int key;
  function automatic logic [7:0] ini(input int k);
    return 8'(k ^ (k >> 8) ^ (k >> 16) ^ 32'h0000_005a);
  endfunction
  assign key = {15'h0000, lat_prog, lat_addr};
  always @(posedge clock) begin
    if (addr_latch_strobe_n === 1'b0) begin
      lat_addr = {high_addr, bus};
      lat_write = !read_write;
      lat_prog = program_data_sel;
    end
    if (data_strobe_n === 1'b0 && read_write === 1'b0) begin
      wr_data = bus;
      mem[key] = bus;
    end
    last <= bus;
  end
  // Released bus shows a changing pattern, so stale data never passes as a read.
  always @* begin
    drive = ~last;
    if (data_strobe_n === 1'b0 && read_write === 1'b1) drive = mem.exists(key) ? mem[key] : ini(key);
  end
endmodule
`default_nettype wire

/* File: tb/external_memory_bus_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module external_memory_bus_port_bench;
  logic clock = 1'b0, rst = 1'b1, clock_en = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_program = 1'b0;
  logic req_internal = 1'b0, float_request = 1'b0, external_wait = 1'b0, external_bus_request = 1'b0;
  logic [15:0] req_addr = 16'h0000, start_address, lat_addr;
  logic [7:0] req_wdata = 8'h00, rsp_rdata, mux_addr_data_out, high_addr, drive, wr_data;
  logic req_ready, rsp_valid, vector_valid, addr_latch_strobe_n, addr_latch_strobe_oe_n, data_strobe_n;
  logic data_strobe_oe_n, read_write, read_write_oe_n, program_data_sel, mux_addr_data_oe_n, high_addr_oe_n;
  logic external_bus_grant, lat_write, lat_prog;
  wire logic [7:0] bus, mux_addr_data_in;
  int failures = 0, check_count = 0, as_cnt, ds_cnt, rdy_cnt, n;
  logic [7:0] emem [int];
  logic [31:0] r;
  assign bus = mux_addr_data_oe_n ? drive : mux_addr_data_out;
  assign mux_addr_data_in = bus;
  embp_port uut (
    .clock(clock),
    .rst(rst),
    .clock_en(clock_en),
    .req_valid(req_valid),
    .req_addr(req_addr),
    .req_write(req_write),
    .req_program(req_program),
    .req_internal(req_internal),
    .req_wdata(req_wdata),
    .float_request(float_request),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .vector_valid(vector_valid),
    .start_address(start_address),
    .addr_latch_strobe_n(addr_latch_strobe_n),
    .addr_latch_strobe_oe_n(addr_latch_strobe_oe_n),
    .data_strobe_n(data_strobe_n),
    .data_strobe_oe_n(data_strobe_oe_n),
    .read_write(read_write),
    .read_write_oe_n(read_write_oe_n),
    .program_data_sel(program_data_sel),
    .mux_addr_data_in(mux_addr_data_in),
    .mux_addr_data_out(mux_addr_data_out),
    .mux_addr_data_oe_n(mux_addr_data_oe_n),
    .high_addr(high_addr),
    .high_addr_oe_n(high_addr_oe_n),
    .external_wait(external_wait),
    .external_bus_request(external_bus_request),
    .external_bus_grant(external_bus_grant)
  );
  embp_mem_model partner (
    .clock(clock),
    .addr_latch_strobe_n(addr_latch_strobe_n),
    .data_strobe_n(data_strobe_n),
    .read_write(read_write),
    .program_data_sel(program_data_sel),
    .high_addr(high_addr),
    .bus(bus),
    .drive(drive),
    .lat_addr(lat_addr),
    .lat_write(lat_write),
    .lat_prog(lat_prog),
    .wr_data(wr_data)
  );
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    as_cnt += int'(addr_latch_strobe_n === 1'b0);
    ds_cnt += int'(data_strobe_n === 1'b0);
    rdy_cnt += int'(req_ready === 1'b1);
  end
  function automatic logic [7:0] em(input int k);
    return emem.exists(k) ? emem[k] : 8'(k ^ (k >> 8) ^ (k >> 16) ^ 32'h0000_005a);
  endfunction
  task automatic stop_test;
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, p, i, input logic [15:0] a, input logic [7:0] d, input int wt);
    int k;
    k = {15'h0000, p, a};
    as_cnt = 0;
    ds_cnt = 0;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_program <= p;
    req_internal <= i;
    req_addr <= a;
    req_wdata <= d;
    external_wait <= (wt > 0);
    do @(posedge clock); while (req_ready !== 1'b1 && ++n < 50);
    req_valid <= 1'b0;
    repeat (wt) @(posedge clock);
    external_wait <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n++ < 50) @(posedge clock);
    `CHK(rsp_valid, 1'b1)
    if (!w && !i) `CHK(rsp_rdata, em(k))
    if (w && !i) begin `CHK(wr_data, d)
      emem[k] = d;
    end
    `CHK(lat_addr, a)
    `CHK(lat_write, w && !i)
    `CHK(lat_prog, p)
    `CHK(as_cnt, 1)
    if (i) `CHK(ds_cnt, 0)
    else if (wt > 0) `CHK(ds_cnt > 3, 1'b1)
    else `CHK(ds_cnt, embp_pkg::EMBP_DATA_CYCLES)
    @(posedge clock);
  endtask
  initial begin
    void'($urandom(89));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    n = 0;
    while (vector_valid !== 1'b1 && n++ < 300) @(posedge clock);
    `CHK(vector_valid, 1'b1)
    `CHK(start_address, {em(32'h0001_0000), em(32'h0001_0001)})
    for (int t = 0; t < 60; t++) begin
      r = $urandom;
      xfer(r[0], r[1], r[3:2] == 2'b00, {r[31:30], 10'h000, r[19:16]}, r[15:8], (r[5:4] == 2'b00 && r[3:2] != 2'b00) ? 3 : 0);
    end
    // ============================================================
    // Float and bus hand-over: the core must be refused meanwhile.
    float_request <= 1'b1;
    repeat (4) @(posedge clock);
    rdy_cnt = 0;
    req_valid <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK({addr_latch_strobe_oe_n, data_strobe_oe_n, read_write_oe_n, mux_addr_data_oe_n, high_addr_oe_n}, 5'h1f)
    `CHK(rdy_cnt, 0)
    req_valid <= 1'b0;
    float_request <= 1'b0;
    repeat (4) @(posedge clock);
    external_bus_request <= 1'b1;
    n = 0;
    do @(posedge clock); while (external_bus_grant !== 1'b1 && ++n < 30);
    `CHK({addr_latch_strobe_oe_n, data_strobe_oe_n, read_write_oe_n, mux_addr_data_oe_n, high_addr_oe_n}, 5'h1f)
    `CHK(external_bus_grant, 1'b1)
    // With the clock enable low the withdrawal must not be seen, so the grant stays frozen.
    clock_en <= 1'b0;
    external_bus_request <= 1'b0;
    repeat (6) @(posedge clock);
    `CHK(external_bus_grant, 1'b1)
    clock_en <= 1'b1;
    repeat (10) @(posedge clock);
    `CHK(external_bus_grant, 1'b0)
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    stop_test;
  end
endmodule
`default_nettype wire
